// ===== common/lcdm_frame_if.sv
/*
 Link between the register side and the frame timing generator.
 Assumes both ends run on the same bus clock.
*/
`timescale 1ns/1ps
interface lcdm_frame_if;
   logic osc_sel;
   logic [2:0] rate;
   logic psave;
   logic [1:0] phase;
   logic pol;
   logic active;
   modport gen (input osc_sel, input rate, input psave,
                output phase, output pol, output active);
   modport user (output osc_sel, output rate, output psave,
                 input phase, input pol, input active);
endinterface

// ===== common/lcdm_pkg.sv
/*
 Constants and state types for the multiplexed LCD drive block.
 Assumes a 40 MHz bus clock and word-only AHB-Lite register access.
*/
package lcdm_pkg;
   // Geometry
   localparam int LCDM_NSEG = 35;
   localparam int LCDM_NCOM = 4;
   localparam int LCDM_NBITS = LCDM_NSEG * LCDM_NCOM;
   localparam int LCDM_NPORT = 4;
   localparam int LCDM_PBITS = LCDM_NBITS / LCDM_NPORT;

   // Register byte offsets
   localparam logic [7:0] LCDM_OFS_CTRL = 8'h00;
   localparam logic [7:0] LCDM_OFS_EXT = 8'h04;
   localparam logic [7:0] LCDM_OFS_PORTION0 = 8'h08;
   localparam logic [7:0] LCDM_OFS_STATUS = 8'h18;

   // Control field positions
   localparam int LCDM_CTRL_OSC_SEL = 0;
   localparam int LCDM_CTRL_RATE_LO = 1;
   localparam int LCDM_CTRL_BLANK = 4;
   localparam int LCDM_CTRL_PSAVE = 5;

   // Status field positions
   localparam int LCDM_ST_LOADED_LO = 0;
   localparam int LCDM_ST_INHIBIT_N = 4;
   localparam int LCDM_ST_PHASE_LO = 5;
   localparam int LCDM_ST_POL = 7;
   localparam int LCDM_ST_ACTIVE = 8;

   // Values after reset
   localparam logic LCDM_RST_OSC_SEL = 1'b0;
   localparam logic [2:0] LCDM_RST_RATE = 3'h0;
   localparam logic LCDM_RST_BLANK = 1'b0;
   localparam logic LCDM_RST_PSAVE = 1'b0;

   // Frame rate codes, bit2 first: {bit2,bit1,bit0}
   localparam logic [2:0] LCDM_RATE_768 = 3'h3;
   localparam logic [2:0] LCDM_RATE_576 = 3'h7;
   localparam logic [2:0] LCDM_RATE_384 = 3'h0;
   localparam logic [2:0] LCDM_RATE_288 = 3'h4;
   localparam logic [2:0] LCDM_RATE_192 = 3'h2;

   // Frame dividers in source clocks
   localparam int LCDM_DIV_768 = 768;
   localparam int LCDM_DIV_576 = 576;
   localparam int LCDM_DIV_384 = 384;
   localparam int LCDM_DIV_288 = 288;
   localparam int LCDM_DIV_192 = 192;

   // Internal RC oscillator emulation
   localparam real LCDM_CLK_MHZ = 40.0;
   localparam real LCDM_RC_KHZ = 38.0;
   localparam int LCDM_RC_DIV = int'(LCDM_CLK_MHZ * 1000.0 / LCDM_RC_KHZ);

   // Drive level codes, one-third bias
   localparam logic [1:0] LCDM_LVL_VSS = 2'h0;
   localparam logic [1:0] LCDM_LVL_V1 = 2'h1;
   localparam logic [1:0] LCDM_LVL_V2 = 2'h2;
   localparam logic [1:0] LCDM_LVL_VDD = 2'h3;

   typedef struct packed {
      logic [10:0] rc_cnt;
      logic osc_q;
      logic [7:0] qcnt;
      logic [1:0] phase;
      logic pol;
      logic active;
   } lcdm_gen_st_t;

   typedef struct packed {
      logic osc_sel;
      logic [2:0] rate;
      logic blank;
      logic psave;
      logic [2:0] ext;
      logic [LCDM_NBITS-1:0] data;
      logic [3:0] loaded;
      logic wr_pend;
      logic rd_pend;
      logic [7:0] addr;
      logic hready;
      logic hresp;
      logic [31:0] hrdata;
      logic [2*LCDM_NCOM-1:0] com;
      logic [2*LCDM_NSEG-1:0] seg;
   } lcdm_top_st_t;
endpackage

// ===== hw/lcdm_drive.sv
/*
 Multiplexed LCD drive top: AHB-Lite register slave, display latches and
 one-quarter duty, one-third bias output levels. Assumes a single
 AHB-Lite master and that the inhibit and oscillator pins are synchronous.
*/
`timescale 1ns/1ps
module lcdm_drive
   import lcdm_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Panel pins
   input wire logic display_inhibit_n,
   input wire logic oscillator_pin,
   output logic [2*LCDM_NCOM-1:0] common_level,
   output logic [2*LCDM_NSEG-1:0] segment_level
);
   lcdm_top_st_t st_r;
   lcdm_top_st_t st_nxt;
   lcdm_frame_if fr ();

   lcdm_frame_gen u_gen (
      .hclk(hclk),
      .hresetn(hresetn),
      .oscillator_pin(oscillator_pin),
      .fr(fr)
   );

   assign fr.osc_sel = st_r.osc_sel;
   assign fr.rate = st_r.rate;
   assign fr.psave = st_r.psave;

   // Level of a common in the current phase
   function automatic logic [1:0] com_lvl(input logic sel, input logic pol);
      if (sel)
         return pol ? LCDM_LVL_VSS : LCDM_LVL_VDD;
      else
         return pol ? LCDM_LVL_V2 : LCDM_LVL_V1;
   endfunction

   // Level of a segment for its on/off bit
   function automatic logic [1:0] seg_lvl(input logic on, input logic pol);
      if (on)
         return pol ? LCDM_LVL_VDD : LCDM_LVL_VSS;
      else
         return pol ? LCDM_LVL_V1 : LCDM_LVL_V2;
   endfunction

   // Index of a portion register, 4 when not one
   function automatic logic [2:0] portion_of(input logic [7:0] a);
      logic [7:0] d;
      d = a - LCDM_OFS_PORTION0;
      if (a >= LCDM_OFS_PORTION0 && d[7:4] == 4'h0 && d[1:0] == 2'h0)
         return {1'b0, d[3:2]};
      else
         return 3'h4;
   endfunction

   logic [31:0] rd_val;
   logic [2:0] wp;
   logic [2:0] rp;
   logic [LCDM_PBITS-1:0] pword;
   logic take;
   logic drive_on;

   always_comb
   begin
      st_nxt = st_r;
      rd_val = 32'h0000_0000;
      pword = '0;
      st_nxt.hresp = 1'b0;
      take = hsel & hready & htrans[1];
      wp = portion_of(st_r.addr);
      rp = portion_of(st_r.addr);

      // Write data phase, zero wait
      if (st_r.wr_pend)
      begin
         if (st_r.addr == LCDM_OFS_CTRL)
         begin
            st_nxt.osc_sel = hwdata[LCDM_CTRL_OSC_SEL];
            st_nxt.rate = hwdata[LCDM_CTRL_RATE_LO +: 3];
            st_nxt.blank = hwdata[LCDM_CTRL_BLANK];
            st_nxt.psave = hwdata[LCDM_CTRL_PSAVE];
         end
         else if (st_r.addr == LCDM_OFS_EXT)
         begin
            st_nxt.ext = hwdata[2:0];
         end
         else if (wp != 3'h4)
         begin
            pword = {st_r.ext, hwdata};
            st_nxt.data[32'(wp) * LCDM_PBITS +: LCDM_PBITS] = pword;
            st_nxt.loaded[wp[1:0]] = 1'b1;
         end
      end

      // Read data, one wait state
      if (st_r.addr == LCDM_OFS_CTRL)
      begin
         rd_val[LCDM_CTRL_OSC_SEL] = st_r.osc_sel;
         rd_val[LCDM_CTRL_RATE_LO +: 3] = st_r.rate;
         rd_val[LCDM_CTRL_BLANK] = st_r.blank;
         rd_val[LCDM_CTRL_PSAVE] = st_r.psave;
      end
      else if (st_r.addr == LCDM_OFS_EXT)
      begin
         rd_val[2:0] = st_r.ext;
      end
      else if (st_r.addr == LCDM_OFS_STATUS)
      begin
         rd_val[LCDM_ST_LOADED_LO +: 4] = st_r.loaded;
         rd_val[LCDM_ST_INHIBIT_N] = display_inhibit_n;
         rd_val[LCDM_ST_PHASE_LO +: 2] = fr.phase;
         rd_val[LCDM_ST_POL] = fr.pol;
         rd_val[LCDM_ST_ACTIVE] = fr.active;
      end
      else if (rp != 3'h4)
      begin
         rd_val = st_r.data[32'(rp) * LCDM_PBITS +: 32];
      end

      st_nxt.wr_pend = 1'b0;
      st_nxt.rd_pend = 1'b0;
      if (st_r.rd_pend)
      begin
         st_nxt.hrdata = rd_val;
         st_nxt.hready = 1'b1;
      end
      else if (take)
      begin
         st_nxt.addr = haddr[7:0];
         if (haddr[31:8] != 24'h000000)
            st_nxt.addr = 8'hff;
         st_nxt.wr_pend = hwrite;
         st_nxt.rd_pend = ~hwrite;
         st_nxt.hready = hwrite;
      end

      // Output levels
      drive_on = display_inhibit_n & ~st_r.psave & fr.active;
      for (int c = 0; c < LCDM_NCOM; c++)
      begin
         if (drive_on)
            st_nxt.com[2*c +: 2] =
               com_lvl(fr.phase == 2'(c), fr.pol);
         else
            st_nxt.com[2*c +: 2] = LCDM_LVL_VSS;
      end
      for (int s = 0; s < LCDM_NSEG; s++)
      begin
         if (drive_on)
            st_nxt.seg[2*s +: 2] = seg_lvl(
               ~st_r.blank & st_r.data[LCDM_NCOM*s + 32'(fr.phase)],
               fr.pol);
         else
            st_nxt.seg[2*s +: 2] = LCDM_LVL_VSS;
      end
   end

   // Latches cleared at reset for determinism only
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_r <= '0;
         st_r.osc_sel <= LCDM_RST_OSC_SEL;
         st_r.rate <= LCDM_RST_RATE;
         st_r.blank <= LCDM_RST_BLANK;
         st_r.psave <= LCDM_RST_PSAVE;
         st_r.hready <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign hreadyout = st_r.hready;
   assign hresp = st_r.hresp;
   assign hrdata = st_r.hrdata;
   assign common_level = st_r.com;
   assign segment_level = st_r.seg;
endmodule

// ===== hw/lcdm_frame_gen.sv
/*
 Frame timing generator: picks the source clock, divides it and steps
 through the four common phases. Assumes the oscillator pin is already
 synchronous to hclk.
*/
`timescale 1ns/1ps
module lcdm_frame_gen
   import lcdm_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Oscillator pin
   input wire logic oscillator_pin,
   // Control and phase
   lcdm_frame_if.gen fr
);
   lcdm_gen_st_t st_r;
   lcdm_gen_st_t st_nxt;

   // Quarter of the frame divider for a rate code
   function automatic logic [7:0] quarter(input logic [2:0] code);
      int d;
      unique case (code)
         LCDM_RATE_768: d = LCDM_DIV_768;
         LCDM_RATE_576: d = LCDM_DIV_576;
         LCDM_RATE_288: d = LCDM_DIV_288;
         LCDM_RATE_192: d = LCDM_DIV_192;
         default: d = LCDM_DIV_384;
      endcase
      return 8'(d / LCDM_NCOM);
   endfunction

   logic tick;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.osc_q = oscillator_pin;
      tick = 1'b0;
      if (fr.psave)
      begin
         st_nxt.rc_cnt = '0;
         st_nxt.qcnt = '0;
         st_nxt.phase = '0;
         st_nxt.pol = 1'b0;
         st_nxt.active = 1'b0;
      end
      else
      begin
         if (fr.osc_sel)
         begin
            tick = oscillator_pin & ~st_r.osc_q;
            st_nxt.rc_cnt = '0;
         end
         else if (st_r.rc_cnt == 11'(LCDM_RC_DIV - 1))
         begin
            tick = 1'b1;
            st_nxt.rc_cnt = '0;
         end
         else
         begin
            st_nxt.rc_cnt = st_r.rc_cnt + 11'h001;
         end
         if (tick)
         begin
            st_nxt.active = 1'b1;
            if (st_r.qcnt >= quarter(fr.rate) - 8'h01)
            begin
               st_nxt.qcnt = '0;
               st_nxt.phase = st_r.phase + 2'h1;
               if (st_r.phase == 2'h3)
                  st_nxt.pol = ~st_r.pol;
            end
            else
            begin
               st_nxt.qcnt = st_r.qcnt + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign fr.phase = st_r.phase;
   assign fr.pol = st_r.pol;
   assign fr.active = st_r.active;
endmodule

// ===== verif/lcdm_ctl_model.sv
/*
 Far-side model: external clock source and inhibit driver.
 Assumes it is stepped by the bench clock.
*/
`timescale 1ns/1ps
module lcdm_ctl_model (
   // Clock
   input wire logic hclk,
   // Bench control
   input wire logic osc_run,
   input wire logic data_sent,
   // Pins
   output logic oscillator_pin,
   output logic display_inhibit_n
);
   logic [1:0] cnt_r = 2'h0;
   // Four hclk per period, stands still when stopped
   always @(posedge hclk)
      if (osc_run)
         cnt_r <= cnt_r + 2'h1;
   assign oscillator_pin = cnt_r[1];
   // Inhibit low until all data sent
   assign display_inhibit_n = data_sent;
endmodule

// ===== verif/lcdm_drive_props.sv
/*
 Assertions for the LCD drive top.
 Sees only the top ports; bound to every lcdm_drive below.
*/
`timescale 1ns/1ps
module lcdm_drive_props
   import lcdm_pkg::*;
(
   // Bus
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // Panel
   input wire logic display_inhibit_n,
   input wire logic [2*LCDM_NCOM-1:0] common_level,
   input wire logic [2*LCDM_NSEG-1:0] segment_level
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // One-hot of the selected common
   function automatic logic [3:0] selv(logic [7:0] c);
      selv = {c[7], c[5], c[3], c[1]} ^ {4{~c[0]}};
   endfunction
   function automatic logic [34:0] seg_lo(logic [69:0] v);
      for (int k = 0; k < 35; k++)
         seg_lo[k] = v[2*k];
   endfunction
   sequence rd_taken;
      hsel && hready && htrans[1] && !hwrite;
   endsequence
   sequence wr_taken;
      hsel && hready && htrans[1] && hwrite;
   endsequence
   sequence wait_then_ready;
      !hreadyout ##1 hreadyout;
   endsequence
   sequence step;
      common_level != 0 && $past(common_level) != 0 && $changed(common_level);
   endsequence
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   a_read_wait: assert property (rd_taken |=> wait_then_ready)
      else $error("read wait state wrong");
   a_write_nowait: assert property (wr_taken |=> hreadyout)
      else $error("write stalled");
   a_inhibit_ground: assert property (!display_inhibit_n [*3] |->
      common_level == 0 && segment_level == 0)
      else $error("inhibit did not ground outputs");
   a_common_shape: assert property (common_level != 0 |->
      {common_level[6], common_level[4], common_level[2]} ==
      {3{common_level[0]}} && $onehot(selv(common_level)))
      else $error("common levels malformed");
   a_seg_polarity: assert property (common_level != 0 |->
      seg_lo(segment_level) == {35{~common_level[0]}})
      else $error("segment polarity mismatch");
   a_phase_order: assert property (step |->
      selv(common_level) == ((selv($past(common_level)) << 1) |
      (selv($past(common_level)) >> 3)))
      else $error("common phase out of order");
   a_pol_flip: assert property (step |->
      (common_level[0] != $past(common_level[0])) ==
      ($past(common_level[7]) == $past(common_level[0])))
      else $error("polarity flip wrong");
endmodule

bind lcdm_drive lcdm_drive_props lcdm_drive_props_inst (
   .hclk(hclk),
   .hresetn(hresetn),
   .hsel(hsel),
   .htrans(htrans),
   .hwrite(hwrite),
   .hready(hready),
   .hreadyout(hreadyout),
   .hresp(hresp),
   .display_inhibit_n(display_inhibit_n),
   .common_level(common_level),
   .segment_level(segment_level)
);

// ===== verif/lcdm_drive_tb.sv
/*
 Self-checking bench for the LCD drive top.
 Assumes the far-side model and the checker are compiled first.
*/
`timescale 1ns/1ps
module lcdm_drive_tb
   import lcdm_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [1:0] htrans;
   logic [2:0] hsize, ext;
   logic [31:0] haddr, hwdata, hrdata, q, d;
   logic osc_run, data_sent, oscillator_pin, display_inhibit_n;
   logic [7:0] common_level, c;
   logic [2*LCDM_NSEG-1:0] segment_level;
   logic [LCDM_NBITS-1:0] mdl;
   // Last entry is an unlisted code, which runs at the 384 divider
   logic [2:0] codes [6] = '{LCDM_RATE_768, LCDM_RATE_576, LCDM_RATE_384,
      LCDM_RATE_288, LCDM_RATE_192, 3'h5};
   int divs [6] = '{LCDM_DIV_768, LCDM_DIV_576, LCDM_DIV_384,
      LCDM_DIV_288, LCDM_DIV_192, LCDM_DIV_384};
   int mismatches = 0, n_tests = 0, cyc = 0, n;
   assign hready = hreadyout;
   lcdm_drive lcdm_drive_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .display_inhibit_n(display_inhibit_n),
      .oscillator_pin(oscillator_pin), .common_level(common_level),
      .segment_level(segment_level));
   lcdm_ctl_model lcdm_ctl_model_inst (.hclk(hclk), .osc_run(osc_run),
      .data_sent(data_sent), .oscillator_pin(oscillator_pin),
      .display_inhibit_n(display_inhibit_n));
   initial
   begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         mismatches++;
         end_of_test();
      end
   end
   task end_of_test();
      $display("Checks %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [69:0] got, input logic [69:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Single AHB-Lite transfer, entered just after a rising edge
   task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      hsel <= 1'b1;
      hsize <= 3'h2;
      do @(negedge hclk); while (hreadyout !== 1'b1);
      @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(negedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
      @(posedge hclk);
   endtask
   task phase_len();
      @(negedge hclk);
      c = common_level;
      while (common_level === c) @(negedge hclk);
      c = common_level;
      n = 0;
      while (common_level === c)
      begin
         @(negedge hclk);
         n++;
      end
      c = common_level;
      @(posedge hclk);
   endtask
   // Expected segments from model data and the present phase
   task seg_chk(input logic b);
      logic [3:0] s;
      logic [69:0] e;
      logic o;
      int i;
      @(negedge hclk);
      s = {common_level[7], common_level[5], common_level[3],
         common_level[1]} ^ {4{~common_level[0]}};
      i = s[3] ? 3 : s[2] ? 2 : s[1] ? 1 : 0;
      for (int k = 0; k < LCDM_NSEG; k++)
      begin
         o = mdl[4*k+i] & ~b;
         e[2*k+:2] = common_level[0] ? {~o, 1'b0} : {o, 1'b1};
      end
      chk(segment_level, e);
      @(posedge hclk);
   endtask
   task zero_chk();
      @(negedge hclk);
      chk(segment_level, 70'h0);
      chk(70'(common_level), 70'h0);
      @(posedge hclk);
   endtask
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      osc_run = 1'b0;
      data_sent = 1'b0;
      void'($urandom(93));
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, 32'(LCDM_OFS_CTRL), 32'h0);
      chk(70'(q), 70'h0);
      for (int k = 0; k < 4; k++)
      begin
         ext = 3'($urandom);
         d = $urandom;
         mdl[35*k+:35] = {ext, d};
         bus(1'b1, 32'(LCDM_OFS_EXT), 32'(ext));
         bus(1'b1, 32'(LCDM_OFS_PORTION0) + 4*k, d);
      end
      for (int k = 0; k < 4; k++)
      begin
         bus(1'b0, 32'(LCDM_OFS_PORTION0) + 4*k, 32'h0);
         chk(70'(q), 70'(mdl[35*k+:32]));
      end
      bus(1'b0, 32'(LCDM_OFS_STATUS), 32'h0);
      chk(70'(q[3:0]), 70'hf);
      bus(1'b0, 32'h100, 32'h0);
      chk(70'(q), 70'h0);
      $display("Load test done");
      bus(1'b1, 32'(LCDM_OFS_CTRL), 32'({LCDM_RATE_192, 1'b1}));
      osc_run <= 1'b1;
      repeat (400) @(posedge hclk);
      zero_chk();
      data_sent <= 1'b1;
      for (int r = 0; r < 6; r++)
      begin
         bus(1'b1, 32'(LCDM_OFS_CTRL), 32'({codes[r], 1'b1}));
         phase_len();
         chk(70'(n), 70'(divs[r]));
         seg_chk(1'b0);
         $display("Rate test %0d done", r);
      end
      bus(1'b1, 32'(LCDM_OFS_CTRL), 32'({1'b1, LCDM_RATE_192, 1'b1}));
      phase_len();
      seg_chk(1'b1);
      data_sent <= 1'b0;
      repeat (4) @(posedge hclk);
      zero_chk();
      data_sent <= 1'b1;
      $display("Blank and inhibit test done");
      bus(1'b1, 32'(LCDM_OFS_CTRL), 32'({LCDM_RATE_192, 1'b1}));
      phase_len();
      osc_run <= 1'b0;
      repeat (600) @(posedge hclk);
      chk(70'(common_level), 70'(c));
      bus(1'b1, 32'(LCDM_OFS_CTRL), 32'({LCDM_RATE_192, 1'b0}));
      n = 0;
      while (common_level === c && n < 60000)
      begin
         @(negedge hclk);
         n++;
      end
      @(posedge hclk);
      chk(70'(n <= 48 * LCDM_RC_DIV + 8), 70'h1);
      $display("Source test done");
      osc_run <= 1'b1;
      bus(1'b1, 32'(LCDM_OFS_CTRL), 32'h21);
      repeat (8) @(posedge hclk);
      zero_chk();
      $display("Power save test done");
      end_of_test();
   end
endmodule
